// ===== common/oss_map.vh
`ifndef OSS_MAP_VH
`define OSS_MAP_VH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define OSS_OFS_TRIM 8'h00
`define OSS_OFS_STAT 8'h04
`define OSS_OFS_CFG2 8'h08
`define OSS_OFS_PUE 8'h0C
// ****************************************************************
// field positions
// ****************************************************************
`define OSS_STAT_REQ_BIT 0
`define OSS_STAT_ACT_BIT 1
`define OSS_PUE_CLKOUT_BIT 1
// ****************************************************************
// reset values
// ****************************************************************
`define OSS_TRIM_RST 8'h80
`define OSS_SEL_RST 2'h0
// ****************************************************************
// source select codes
// ****************************************************************
`define OSS_SEL_INT 2'h0
`define OSS_SEL_EXT 2'h1
`define OSS_SEL_RC 2'h2
`define OSS_SEL_XTAL 2'h3
// ****************************************************************
// internal oscillator model (phase step per system clock)
// ****************************************************************
`define OSS_INT_NOM_INC 17'h0CCCD
`define OSS_TRIM_BIAS 17'h02000
`define OSS_TRIM_SHIFT 6
`define OSS_EDGES_NEEDED 2'h2
`endif

// ===== hw/oss_int_osc.v
`timescale 1ns/100ps
// ****************************************************************
// trimmable internal oscillator, phase accumulator on clk_sys
// ****************************************************************
`include "oss_map.vh"
module oss_int_osc
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // control
   input wire run,
   input wire [7:0] trim,
   // oscillator level
   output reg lvl_ff
);
   reg [15:0] acc_ff; // phase accumulator
   wire [16:0] step; // per-cycle phase step
   wire [16:0] sum; // accumulator plus step
   wire [16:0] trim_term; // trim scaled to step units

   // larger trim gives a smaller step, so a longer period
   assign trim_term = {3'h0, trim, 6'h00};
   assign step = `OSS_INT_NOM_INC + `OSS_TRIM_BIAS - trim_term;
   assign sum = {1'b0, acc_ff} + step;

   // toggle level on each carry out of the accumulator
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_ff <= 16'h0000;
         lvl_ff <= 1'b0;
      end
      else if (run)
      begin
         acc_ff <= sum[15:0];
         if (sum[16])
         begin
            lvl_ff <= ~lvl_ff;
         end
      end
      else
      begin
         // stopped oscillator parks low
         acc_ff <= 16'h0000;
         lvl_ff <= 1'b0;
      end
   end
endmodule

// ===== hw/oss_clk_gen.v
`timescale 1ns/100ps
// ****************************************************************
// output clock mux and half-rate divider
// ****************************************************************
module oss_clk_gen
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // sources
   input wire int_lvl,
   input wire ext_lvl,
   input wire use_ext,
   input wire stop_mode,
   // clocks out
   output reg fast_sys_clk,
   output reg half_rate_clk
);
   wire nxt_fast; // selected source level

   // internal source unless the switch is complete
   assign nxt_fast = use_ext ? ext_lvl : int_lvl;

   // registered mux; stop holds both clocks low
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fast_sys_clk <= 1'b0;
         half_rate_clk <= 1'b0;
      end
      else if (stop_mode)
      begin
         fast_sys_clk <= 1'b0;
         half_rate_clk <= 1'b0;
      end
      else
      begin
         fast_sys_clk <= nxt_fast;
         // toggle on each rising edge of the fast clock
         if (nxt_fast && !fast_sys_clk)
         begin
            half_rate_clk <= ~half_rate_clk;
         end
      end
   end
endmodule

// ===== hw/oss_switch.v
// Operation
// - make fast clock and half-rate clock
// - reset selects internal oscillator source
// - internal oscillator nominally sixteen megahertz
// - clock-out enable drives fast clock out; code does so only with internal or RC select
// - eight-bit trim register adjusts period
// - larger trim gives longer period
// - reset loads trim with 80 hex
// - select makes input pin external clock
// - wait two external rising edges first
// - switch sources without glitches or runts
// - set active flag, then stop internal
// - internal restarts only through reset
// - no clock monitor, no fallback
// - select codes internal, ext, RC, crystal
// - half-rate clock is fast divided two
// - stop disables source and both clocks; code stops the internal source and both clocks, crystal drive keeps running
// - reset clears switch request bit
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "oss_map.vh"
module oss_switch
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // low power
   input wire stop_mode,
   // oscillator input pin
   input wire osc_in_pin,
   output wire osc_in_ext_en,
   // oscillator output pin, shared with port c bit 1
   input wire port_c_bit1_out,
   input wire port_c_bit1_oe_n,
   output wire osc_out_pin_o,
   output wire osc_out_pin_oe_n,
   // clocks out
   output wire fast_sys_clk,
   output wire half_rate_clk,
   output wire internal_osc_run
);
   // ****************************************************************
   // switch state machine codes
   // ****************************************************************
   localparam ST_INT = 2'h0; // running on internal source
   localparam ST_CHECK = 2'h1; // counting external edges
   localparam ST_ALIGN = 2'h2; // waiting for both sources low
   localparam ST_EXT = 2'h3; // running on external source

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg [7:0] internal_osc_trim_ff; // trim register
   reg [1:0] source_select_ff; // config two select bits
   reg ext_switch_request_ff; // switch request bit
   reg ext_clock_active_ff; // switch done flag
   reg clk_out_pin_en_ff; // clock-out enable in pull-up reg
   reg int_run_ff; // internal oscillator enable
   reg [1:0] state_ff; // switch state
   reg [1:0] nxt_state; // next switch state
   reg [1:0] edge_cnt_ff; // external rising edges seen
   reg [1:0] nxt_edge_cnt; // next edge count
   reg ext_prev_ff; // previous input pin sample
   reg [31:0] nxt_rdata; // read mux
   reg addr_ok; // mapped address
   wire setup; // apb setup phase
   wire wr_acc; // write taken this edge
   wire ext_rise; // rising edge on input pin
   wire int_lvl; // internal oscillator level
   wire src_is_xtal; // crystal source chosen
   wire drive_clk_out; // output pin carries fast clock

   // ****************************************************************
   // apb access
   // ****************************************************************
   assign setup = psel && !penable;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_acc = psel && penable && pwrite && addr_ok;

   // address decode and read data select
   always @*
   begin
      addr_ok = 1'b1;
      nxt_rdata = 32'h00000000;
      case (paddr)
         `OSS_OFS_TRIM:
         begin
            nxt_rdata[7:0] = internal_osc_trim_ff;
         end
         `OSS_OFS_STAT:
         begin
            nxt_rdata[`OSS_STAT_REQ_BIT] = ext_switch_request_ff;
            nxt_rdata[`OSS_STAT_ACT_BIT] = ext_clock_active_ff;
         end
         `OSS_OFS_CFG2:
         begin
            nxt_rdata[1:0] = source_select_ff;
         end
         `OSS_OFS_PUE:
         begin
            nxt_rdata[`OSS_PUE_CLKOUT_BIT] = clk_out_pin_en_ff;
         end
         default:
         begin
            // unmapped: error and zero data
            addr_ok = 1'b0;
         end
      endcase
   end

   // read data captured in setup, stands through access
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
      end
      else if (setup && !pwrite)
      begin
         prdata <= nxt_rdata;
      end
   end

   // ****************************************************************
   // software registers
   // ****************************************************************
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         internal_osc_trim_ff <= `OSS_TRIM_RST;
         source_select_ff <= `OSS_SEL_RST;
         ext_switch_request_ff <= 1'b0;
         clk_out_pin_en_ff <= 1'b0;
      end
      else if (wr_acc)
      begin
         case (paddr)
            `OSS_OFS_TRIM:
            begin
               internal_osc_trim_ff <= pwdata[7:0];
            end
            `OSS_OFS_STAT:
            begin
               // request bit only; active flag is read-only
               ext_switch_request_ff <= pwdata[`OSS_STAT_REQ_BIT];
            end
            `OSS_OFS_CFG2:
            begin
               source_select_ff <= pwdata[1:0];
            end
            `OSS_OFS_PUE:
            begin
               clk_out_pin_en_ff <= pwdata[`OSS_PUE_CLKOUT_BIT];
            end
            default:
            begin
               // nothing stored on unmapped write
               clk_out_pin_en_ff <= clk_out_pin_en_ff;
            end
         endcase
      end
   end

   // ****************************************************************
   // external edge detect (pin is synchronous to clk_sys)
   // ****************************************************************
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_prev_ff <= 1'b0;
      end
      else
      begin
         ext_prev_ff <= osc_in_pin;
      end
   end

   assign ext_rise = osc_in_pin && !ext_prev_ff;

   // ****************************************************************
   // internal to external switch sequence
   // ****************************************************************
   always @*
   begin
      nxt_state = state_ff;
      nxt_edge_cnt = edge_cnt_ff;
      case (state_ff)
         ST_INT:
         begin
            // start only with an external source chosen
            if (ext_switch_request_ff && source_select_ff != `OSS_SEL_INT)
            begin
               nxt_state = ST_CHECK;
               nxt_edge_cnt = 2'h0;
            end
         end
         ST_CHECK:
         begin
            // activity proven by two rising edges
            if (!ext_switch_request_ff)
            begin
               nxt_state = ST_INT;
            end
            else if (ext_rise)
            begin
               nxt_edge_cnt = edge_cnt_ff + 2'h1;
               if (nxt_edge_cnt == `OSS_EDGES_NEEDED)
               begin
                  nxt_state = ST_ALIGN;
               end
            end
         end
         ST_ALIGN:
         begin
            // hand over only while both sources are low
            if (!int_lvl && !osc_in_pin)
            begin
               nxt_state = ST_EXT;
            end
         end
         ST_EXT:
         begin
            // terminal until reset, no fallback
            nxt_state = ST_EXT;
         end
         default:
         begin
            nxt_state = ST_INT;
         end
      endcase
   end

   // state, active flag and internal oscillator enable
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_INT;
         edge_cnt_ff <= 2'h0;
         ext_clock_active_ff <= 1'b0;
         int_run_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         edge_cnt_ff <= nxt_edge_cnt;
         if (state_ff == ST_ALIGN && nxt_state == ST_EXT)
         begin
            ext_clock_active_ff <= 1'b1;
         end
         // internal stops the cycle after active is set
         if (ext_clock_active_ff)
         begin
            int_run_ff <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // clock sources and outputs
   // ****************************************************************
   oss_int_osc u_int_osc
   (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .run (int_run_ff && !stop_mode),
      .trim (internal_osc_trim_ff),
      .lvl_ff (int_lvl)
   );

   oss_clk_gen u_clk_gen
   (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .int_lvl (int_lvl),
      .ext_lvl (osc_in_pin),
      .use_ext (ext_clock_active_ff),
      .stop_mode (stop_mode),
      .fast_sys_clk (fast_sys_clk),
      .half_rate_clk (half_rate_clk)
   );

   assign internal_osc_run = int_run_ff && !stop_mode;

   // ****************************************************************
   // pin functions
   // ****************************************************************
   // input pin becomes clock input once a non-internal source is set
   assign osc_in_ext_en = (source_select_ff != `OSS_SEL_INT);
   assign src_is_xtal = (source_select_ff == `OSS_SEL_XTAL);
   // clock-out allowed for internal or rc source only
   assign drive_clk_out = clk_out_pin_en_ff &&
      (source_select_ff == `OSS_SEL_INT ||
       source_select_ff == `OSS_SEL_RC);

   // crystal: inverted input; clock-out: fast clock; else port bit
   assign osc_out_pin_o = src_is_xtal ? ~osc_in_pin :
      (drive_clk_out ? fast_sys_clk : port_c_bit1_out);
   assign osc_out_pin_oe_n = (src_is_xtal || drive_clk_out) ? 1'b0 :
      port_c_bit1_oe_n;
endmodule

// ===== dv/oss_ext_src.sv
`timescale 1ns/100ps
// ********************
// external clock source at the input pin
// ********************
module oss_ext_src
#(
   parameter real HALF_NS = 60.0
)
(
   // control
   input wire run,
   // clock to the pin
   output reg clk_out
);
   initial clk_out = 1'b0;
   // runs only while enabled, stands low otherwise
   // start offset keeps edges away from both bench clock edges
   always
   begin
      if (run)
         #HALF_NS clk_out = ~clk_out;
      else
      begin
         clk_out = 1'b0;
         @(posedge run);
         #3.5;
      end
   end
endmodule

// ===== dv/oss_switch_monitor.sv
`timescale 1ns/100ps
`include "oss_map.vh"
// ********************
// pin routing and switch checker
// ********************
module oss_switch_monitor
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   // pins and clocks
   input wire stop_mode,
   input wire osc_in_pin,
   input wire osc_in_ext_en,
   input wire port_c_bit1_out,
   input wire port_c_bit1_oe_n,
   input wire osc_out_pin_o,
   input wire osc_out_pin_oe_n,
   input wire fast_sys_clk,
   input wire half_rate_clk,
   input wire internal_osc_run
);
   wire wr = psel && penable && pwrite; // write takes effect
   reg [1:0] sel_ff; // mirrored source select
   reg pue_ff; // mirrored clock-out enable
   reg req_ff; // mirrored switch request
   reg [1:0] cnt_ff; // external rises since request
   reg in_ff; // last input pin sample
   reg stp_ff; // stop seen last cycle
   reg run_ff; // run seen last cycle
   reg sw_ff; // switch to external done
   default clocking dflt_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // mirror register writes and count input edges
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_ff <= 2'h0;
         pue_ff <= 1'b0;
         req_ff <= 1'b0;
         cnt_ff <= 2'h0;
         in_ff <= 1'b0;
         stp_ff <= 1'b0;
         run_ff <= 1'b1;
         sw_ff <= 1'b0;
      end
      else
      begin
         if (wr && paddr == `OSS_OFS_CFG2)
            sel_ff <= pwdata[1:0];
         if (wr && paddr == `OSS_OFS_PUE)
            pue_ff <= pwdata[1];
         if (wr && paddr == `OSS_OFS_STAT)
            req_ff <= pwdata[0];
         if (!req_ff || sel_ff == 2'h0)
            cnt_ff <= 2'h0;
         else if (osc_in_pin && !in_ff && cnt_ff != 2'h3)
            cnt_ff <= cnt_ff + 2'h1;
         in_ff <= osc_in_pin;
         stp_ff <= stop_mode;
         run_ff <= internal_osc_run;
         if (run_ff && !internal_osc_run && !stop_mode && !stp_ff)
            sw_ff <= 1'b1;
      end
   end
   chk_half_follows: assert property (
      disable iff (!rst_n || stop_mode)
      $rose(fast_sys_clk) |-> ##[0:1] $changed(half_rate_clk))
      else $error("half rate clock missed a fast edge");
   chk_clk_out_route: assert property (
      (sel_ff == 2'h0 || sel_ff == 2'h2) && pue_ff |->
      osc_out_pin_o == fast_sys_clk && !osc_out_pin_oe_n)
      else $error("fast clock not on output pin");
   chk_gpio_pass: assert property (sel_ff == 2'h1 ||
      (sel_ff != 2'h3 && !pue_ff) |-> osc_out_pin_o == port_c_bit1_out
      && osc_out_pin_oe_n == port_c_bit1_oe_n)
      else $error("port pin not passed through");
   chk_xtal_drive: assert property (sel_ff == 2'h3 |->
      osc_out_pin_o == !osc_in_pin && !osc_out_pin_oe_n)
      else $error("crystal output not inverted input");
   chk_in_enable: assert property (
      osc_in_ext_en == (sel_ff != 2'h0))
      else $error("input pin enable wrong for select");
   chk_two_edges: assert property ($fell(internal_osc_run) &&
      !stop_mode && !stp_ff |-> cnt_ff >= 2'h2)
      else $error("switched before two external edges");
   chk_no_restart: assert property (sw_ff |-> !internal_osc_run)
      else $error("internal oscillator restarted");
   chk_ext_follow: assert property (sw_ff && !stop_mode && !stp_ff
      |-> fast_sys_clk == $past(osc_in_pin))
      else $error("fast clock not following external");
   chk_stop_low: assert property (stop_mode [*3] |->
      !fast_sys_clk && !half_rate_clk)
      else $error("clocks running in stop");
   chk_reset_int: assert property ($rose(rst_n) |->
      internal_osc_run || stop_mode)
      else $error("internal source not running after reset");
   cov_switch: cover property ($fell(internal_osc_run) && !stop_mode);
   cov_xtal: cover property (sel_ff == 2'h3 && req_ff);
   cov_stop: cover property (stop_mode [*3]);
endmodule
bind oss_switch oss_switch_monitor oss_switch_monitor_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .stop_mode(stop_mode),
   .osc_in_pin(osc_in_pin), .osc_in_ext_en(osc_in_ext_en),
   .port_c_bit1_out(port_c_bit1_out), .port_c_bit1_oe_n(port_c_bit1_oe_n),
   .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_n(osc_out_pin_oe_n),
   .fast_sys_clk(fast_sys_clk), .half_rate_clk(half_rate_clk),
   .internal_osc_run(internal_osc_run));

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`include "oss_map.vh"
module tb_top;
   // ********************
   // pins, model and counters
   // ********************
   reg clk_sys = 1'b0;
   reg rst_n, psel, penable, pwrite, stop_mode, ext_run;
   reg port_c_bit1_out, port_c_bit1_oe_n;
   reg [7:0] paddr, a;
   reg [31:0] pwdata, rd_q;
   reg err_q, prv;
   wire pready, pslverr, osc_in_pin, osc_in_ext_en, osc_out_pin_o;
   wire osc_out_pin_oe_n, fast_sys_clk, half_rate_clk, internal_osc_run;
   wire [31:0] prdata;
   integer fail_count = 0, samples_checked = 0, cyc = 0, seed = 32'h5378;
   integer mdl [0:4]; // register model, slot 4 unmapped
   integer i, n, t, e;
   always #12.5 clk_sys = ~clk_sys;
   oss_switch oss_switch_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .stop_mode(stop_mode), .osc_in_pin(osc_in_pin),
      .osc_in_ext_en(osc_in_ext_en), .port_c_bit1_out(port_c_bit1_out),
      .port_c_bit1_oe_n(port_c_bit1_oe_n), .osc_out_pin_o(osc_out_pin_o),
      .osc_out_pin_oe_n(osc_out_pin_oe_n), .fast_sys_clk(fast_sys_clk),
      .half_rate_clk(half_rate_clk), .internal_osc_run(internal_osc_run));
   oss_ext_src oss_ext_src_inst (.run(ext_run), .clk_out(osc_in_pin));
   // ********************
   // tasks
   // ********************
   task finish_test;
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // compare seen with expected
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function integer ix(input [7:0] ad);
      ix = ad < 8'h10 ? ad >> 2 : 4;
   endfunction
   function [31:0] mk(input integer k);
      mk = k == 0 ? 32'hFF : k == 1 ? 32'h1 : k == 2 ? 32'h3 :
         k == 3 ? 32'h2 : 32'h0;
   endfunction
   // one apb transfer, held until pready
   task apb(input w, input [7:0] ad, input [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input [7:0] ad, input [31:0] d);
      apb(1'b1, ad, d);
      if (ix(ad) < 4)
         mdl[ix(ad)] = (mdl[ix(ad)] & ~mk(ix(ad))) | (d & mk(ix(ad)));
      chk("pslverr", err_q, ix(ad) == 4);
   endtask
   task rd(input [7:0] ad);
      apb(1'b0, ad, 32'h0);
      chk("prdata", rd_q, mdl[ix(ad)]);
      chk("pslverr", err_q, ix(ad) == 4);
   endtask
   task rst_all;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      mdl[0] = `OSS_TRIM_RST;
      for (i = 1; i < 5; i = i + 1)
         mdl[i] = 0;
   endtask
   // rising edges of the fast clock over 2000 cycles
   task cnt_rise(output integer c);
      c = 0;
      prv = fast_sys_clk;
      repeat (2000)
      begin
         @(negedge clk_sys);
         if (fast_sys_clk && !prv)
            c = c + 1;
         prv = fast_sys_clk;
      end
   endtask
   // hang guard
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         fail_count = fail_count + 1;
         finish_test;
      end
   end
   // ********************
   // main sequence
   // ********************
   initial
   begin
      rst_n = 1'b0;
      {psel, penable, pwrite, stop_mode, ext_run, port_c_bit1_out} = 6'h00;
      port_c_bit1_oe_n = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst_all;
      ext_run <= 1'b1;
      for (a = 8'h00; a < 8'h14; a = a + 8'h04)
         rd(a);
      wr(`OSS_OFS_TRIM, $random(seed) & 32'hFF);
      rd(`OSS_OFS_TRIM);
      // trim ends and middle against the phase step
      for (i = 0; i < 3; i = i + 1)
      begin
         t = i == 2 ? 255 : i * 128;
         wr(`OSS_OFS_TRIM, t);
         cnt_rise(n);
         e = 2000 * (52429 + 8192 - 64 * t) / 131072;
         chk("int_rate", n >= e - 3 && n <= e + 3, 1);
      end
      // every select code with clock-out off and on
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(`OSS_OFS_CFG2, i >> 1);
         wr(`OSS_OFS_PUE, (i & 1) << 1);
         t = $random(seed);
         port_c_bit1_out <= t[0];
         port_c_bit1_oe_n <= t[1];
         @(negedge clk_sys);
         chk("ext_en", osc_in_ext_en, i > 1);
         chk("pin", {osc_out_pin_oe_n, osc_out_pin_o}, (i >> 1) == 3 ?
            {1'b0, ~osc_in_pin} : ((i >> 1) != 1 && i[0]) ?
            {1'b0, fast_sys_clk} : {t[1], t[0]});
      end
      // request with the internal source selected is ignored
      wr(`OSS_OFS_CFG2, 0);
      wr(`OSS_OFS_STAT, 1);
      repeat (50) @(posedge clk_sys);
      chk("run", internal_osc_run, 1);
      rd(`OSS_OFS_STAT);
      wr(`OSS_OFS_STAT, 0);
      // crystal: clock-out off so the port bit reaches the pin
      wr(`OSS_OFS_PUE, 0);
      // precharge, select, settle, request
      port_c_bit1_oe_n <= 1'b0;
      port_c_bit1_out <= 1'b1;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("precharge", {osc_out_pin_oe_n, osc_out_pin_o}, 2'h1);
      wr(`OSS_OFS_CFG2, 3);
      port_c_bit1_oe_n <= 1'b1;
      repeat (200) @(posedge clk_sys);
      wr(`OSS_OFS_STAT, 1);
      n = 0;
      while (internal_osc_run !== 1'b0 && n < 300)
      begin
         @(posedge clk_sys);
         n = n + 1;
      end
      chk("run", internal_osc_run, 0);
      mdl[1] = 3;
      rd(`OSS_OFS_STAT);
      cnt_rise(n);
      chk("ext_rate", n >= 413 && n <= 420, 1);
      // external clock dies, no fallback
      ext_run <= 1'b0;
      repeat (100) @(posedge clk_sys);
      chk("run", internal_osc_run, 0);
      chk("fast", fast_sys_clk, 0);
      rd(`OSS_OFS_STAT);
      // stop gates both clocks
      ext_run <= 1'b1;
      stop_mode <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("clks", {fast_sys_clk, half_rate_clk}, 0);
      stop_mode <= 1'b0;
      // second reset brings back the internal source
      rst_all;
      @(posedge clk_sys);
      chk("run", internal_osc_run, 1);
      for (a = 8'h00; a < 8'h10; a = a + 8'h04)
         rd(a);
      finish_test;
   end
endmodule
